// *** hw/mtb_cfg.svh ***
`ifndef MTB_CFG_SVH
`define MTB_CFG_SVH

// ==========================================================
// clocking and timing
`define MTB_CLK_HZ 100000000
`define MTB_CLK_NS 10
`define MTB_OSC_HZ 4000000
`define MTB_PWM_HZ 22800
`define MTB_OSC_DIV (`MTB_CLK_HZ / `MTB_OSC_HZ)
`define MTB_PWM_TICKS (`MTB_OSC_HZ / `MTB_PWM_HZ)
`define MTB_DEAD_NS 200
`define MTB_DEAD_CYC ((`MTB_DEAD_NS + `MTB_CLK_NS - 1) / `MTB_CLK_NS)

// ==========================================================
// register offsets (byte addresses)
`define MTB_REG_CTRL 4'h0
`define MTB_REG_STATUS 4'h4
`define MTB_REG_SETPT 4'h8
`define MTB_REG_FAULT 4'hC

// ==========================================================
// control field positions
`define MTB_CTRL_EN 0
`define MTB_CTRL_SLOPE 1
`define MTB_CTRL_MODE 3
`define MTB_CTRL_DIR 6
`define MTB_CTRL_DBL 7
`define MTB_CTRL_JIT 8
`define MTB_CTRL_RANGE 9

// ==========================================================
// reset values and levels
`define MTB_LFSR_SEED 8'h01
`define MTB_FULL_SCALE 10'h3E8
`define MTB_RDS_THRESH 10'h1F4
`define MTB_FS_START 7'h10

`endif

// *** hw/mtb_pkg.sv ***
package mtb_pkg;

    typedef enum logic [2:0] {
        MTB_M32 = 3'h0,
        MTB_M16 = 3'h1,
        MTB_M8 = 3'h2,
        MTB_M4 = 3'h3,
        MTB_HALF = 3'h4,
        MTB_UHALF = 3'h5,
        MTB_FULL = 3'h6,
        MTB_RSVD = 3'h7
    } mtb_mode_t;

    // gray along forward <-> slow <- fast
    typedef enum logic [1:0] {
        MTB_FWD = 2'h0,
        MTB_SLOW = 2'h1,
        MTB_FAST = 2'h3
    } mtb_decay_t;

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic stepPrev;
        logic waitReq;
        logic [31:0] rdata;
        logic en;
        logic [1:0] slope;
        mtb_mode_t mode;
        logic dirCtl;
        logic dbl;
        logic jit;
        logic [1:0] range;
        logic [6:0] phase;
        logic [1:0] fault;
        logic [1:0] rds;
        logic [7:0] oscDiv;
        logic oscTick;
        logic [7:0] pwmCnt;
        logic pwmStart;
        logic [7:0] lfsr;
    } mtb_main_st_t;

endpackage

// *** hw/mtb_coil_pwm.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mtb_cfg.svh"

module mtb_coil_pwm
    import mtb_pkg::*;
#(
    parameter int DEAD_CYC = `MTB_DEAD_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic bridgeOn,
    input wire logic pwmStart,
    input wire logic [9:0] mag,
    input wire logic neg,
    input wire logic curAbove,
    input wire logic curLimit,
    input wire logic shortOff,
    output logic [1:0] gateHi,
    output logic [1:0] gateLo,
    output logic fastDecay
);

    localparam int DW = $clog2(DEAD_CYC + 1);
    localparam logic [DW-1:0] DEAD_LD = DW'(DEAD_CYC);

    typedef struct packed {
        mtb_decay_t mode;
        logic [9:0] lastMag;
        logic [1:0] hi;
        logic [1:0] lo;
        logic [1:0][DW-1:0] dead;
    } mtb_leg_st_t;

    mtb_leg_st_t s;
    mtb_leg_st_t next_s;
    logic [1:0] wantHi;
    logic [1:0] wantLo;
    logic drop;
    logic off;

    assign drop = mag < s.lastMag;
    assign off = !bridgeOn || shortOff;

    // ==========================================================
    // decay selection and leg control
    always_comb begin
        next_s = s;
        next_s.lastMag = mag;
        wantHi = 2'h0;
        wantLo = 2'h0;
        case (s.mode)
            MTB_FWD: begin
                // current limit ends forward drive at once
                if (curAbove || curLimit) next_s.mode = MTB_SLOW;
            end
            MTB_SLOW: begin
                // forward may restart only on the pwm clock
                if (pwmStart && !curAbove && !curLimit) next_s.mode = MTB_FWD;
            end
            MTB_FAST: begin
                if (pwmStart && !curAbove) next_s.mode = MTB_SLOW;
            end
            default: begin
                next_s.mode = MTB_SLOW;
            end
        endcase
        // no duty cap: forward lasts until the comparator trips
        if (drop) next_s.mode = MTB_FAST;
        if (off) next_s.mode = MTB_SLOW;
        if (!off) begin
            case (s.mode)
                MTB_FWD: begin
                    wantHi = neg ? 2'h2 : 2'h1;
                    wantLo = neg ? 2'h1 : 2'h2;
                end
                MTB_FAST: begin
                    wantHi = neg ? 2'h1 : 2'h2;
                    wantLo = neg ? 2'h2 : 2'h1;
                end
                default: begin
                    wantLo = 2'h3;
                end
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            if ((s.hi[i] && !wantHi[i]) || (s.lo[i] && !wantLo[i])) begin
                next_s.hi[i] = 1'b0;
                next_s.lo[i] = 1'b0;
                next_s.dead[i] = DEAD_LD;
            end else if (s.dead[i] != '0) begin
                next_s.dead[i] = s.dead[i] - DW'(1);
            end else begin
                next_s.hi[i] = wantHi[i];
                next_s.lo[i] = wantLo[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
            s.mode <= MTB_SLOW;
        end else begin
            s <= next_s;
        end
    end

    assign gateHi = s.hi;
    assign gateLo = s.lo;
    assign fastDecay = s.mode == MTB_FAST;

    // ==========================================================
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_no_overlap: assert property ((s.hi & s.lo) == 2'h0)
        else $error("both switches of one half-bridge on");
    chk_dead_gap: assert property ($fell(s.hi[0]) |-> !s.lo[0] [*2])
        else $error("low switch on without dead time");
    chk_off_idle: assert property (!bridgeOn |=> (s.hi | s.lo) == 2'h0)
        else $error("bridge conducts while disabled");
    chk_fast_entry: assert property (drop && !off |=> s.mode == MTB_FAST)
        else $error("no fast decay after setpoint drop");
    chk_fast_cause: assert property (s.mode == MTB_FAST && $past(s.mode) != MTB_FAST
        |-> $past(drop))
        else $error("fast decay in steady regulation");
    chk_limit_slow: assert property (s.mode == MTB_FWD && curLimit |=> s.mode != MTB_FWD)
        else $error("forward drive kept under current limit");

endmodule // mtb_coil_pwm

`default_nettype wire

// *** hw/microstep_translator_bridge_ctrl.sv ***
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mtb_cfg.svh"

// Summary of operation
// - bridge enable low turns every bridge switch off; high lets both bridges drive
// - dead time keeps upper and lower switch of a half-bridge never on together
// - shorts: current limit ends forward drive, over-voltage latches that bridge off
// - two-bit slope select drives the output switching slope
// - comparator against setpoint drives the pwm loop, forward drive starts on pwm clock
// - control bits double pwm frequency and add pwm jitter
// - pwm frequency comes only from the internal clock, adjusted only by the double and jitter bits
// - steady regulation alternates only forward and slow decay
// - setpoint drop selects fast decay automatically
// - low supply: duty rises above half automatically to hold current
// - low-side on-resistance follows current range and step position
// - translator uses mode, direction bit, direction and step pins
// - three-bit mode field selects one of seven translator tables
// - reset leaves 1/32 stepping at position zero
// - same mode: each step moves position by exactly one
// - uncompensated half step drives intermediate currents at full scale
// - uncompensated half step walks the eight square current pairs
// - base pwm about 22.8 kHz, doubled about 46 kHz, from oscillator
// - control oscillator tick runs at 4 MHz
module microstep_translator_bridge_ctrl
    import mtb_pkg::*;
#(
    parameter int OSC_DIV = `MTB_OSC_DIV,
    parameter int PWM_TICKS = `MTB_PWM_TICKS,
    parameter int DEAD_CYC = `MTB_DEAD_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic advance_step_input,
    input wire logic stepDirection,
    input wire logic [1:0] curAbove,
    input wire logic [1:0] curLimit,
    input wire logic [1:0] overVolt,
    output logic bridge_drive_enable,
    output logic [1:0] slope_select,
    output logic [3:0] gateHi,
    output logic [3:0] gateLo,
    output logic [1:0] lowSideRdsonHigh
);

    // ==========================================================
    // constants
    localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);
    localparam logic [7:0] PWM_LAST = 8'(PWM_TICKS - 1);
    localparam logic [7:0] PWM_LAST2 = 8'(PWM_TICKS / 2 - 1);

    // quarter wave of the circular table, tenths of a percent
    localparam logic [9:0] SINE [0:32] = '{
        10'h000, 10'h023, 10'h051, 10'h07F, 10'h0AE, 10'h0DD,
        10'h10B, 10'h13A, 10'h15D, 10'h17F, 10'h1AE, 10'h1D1,
        10'h1F4, 10'h222, 10'h245, 10'h268, 10'h28B, 10'h2AE,
        10'h2D1, 10'h2F3, 10'h316, 10'h33A, 10'h351, 10'h368,
        10'h37F, 10'h396, 10'h3A2, 10'h3AD, 10'h3B9, 10'h3C5,
        10'h3D1, 10'h3DC, 10'h3E8
    };

    // ==========================================================
    // helpers
    function automatic logic [2:0] stepShift(input mtb_mode_t m);
        case (m)
            MTB_M32: stepShift = 3'h0;
            MTB_M16: stepShift = 3'h1;
            MTB_M8: stepShift = 3'h2;
            MTB_M4: stepShift = 3'h3;
            MTB_HALF: stepShift = 3'h4;
            MTB_UHALF: stepShift = 3'h4;
            MTB_FULL: stepShift = 3'h5;
            default: stepShift = 3'h0;
        endcase
    endfunction

    function automatic logic [6:0] startPhase(input mtb_mode_t m);
        startPhase = (m == MTB_FULL) ? `MTB_FS_START : 7'h00;
    endfunction

    // ==========================================================
    // state
    mtb_main_st_t s;
    mtb_main_st_t next_s;
    logic [7:0] pins;
    logic stepEdge;
    logic dirUp;
    logic [6:0] stepSize;
    logic [6:0] posIdx;
    logic [4:0] q;
    logic [5:0] qInv;
    logic [9:0] sinA;
    logic [9:0] sinB;
    logic [2:0] sqIdx;
    logic [1:0][9:0] mag;
    logic [1:0] neg;
    logic [1:0] fastDecay;
    logic [7:0] pwmEnd;
    logic reqNew;
    logic wrDone;
    logic ctrlWr;
    logic modeWr;
    mtb_mode_t wrMode;
    logic [31:0] rdMux;

    assign pins = {overVolt, curLimit, curAbove, stepDirection, advance_step_input};
    assign stepEdge = s.sync2[0] && !s.stepPrev;
    assign dirUp = s.sync2[1] ^ s.dirCtl;
    assign stepSize = 7'h01 << stepShift(s.mode);
    assign posIdx = 7'(s.phase - startPhase(s.mode)) >> stepShift(s.mode);
    assign reqNew = (avs_read || avs_write) && s.waitReq;
    assign wrDone = avs_write && !s.waitReq;
    assign ctrlWr = wrDone && avs_address == `MTB_REG_CTRL && avs_byteenable[0];
    assign wrMode = mtb_mode_t'(avs_writedata[`MTB_CTRL_MODE +: 3]);
    assign modeWr = ctrlWr && wrMode != s.mode;

    // ==========================================================
    // current setpoints from translator phase
    always_comb begin
        q = s.phase[4:0];
        qInv = 6'h20 - {1'b0, q};
        sinA = SINE[q];
        sinB = SINE[qInv];
        sqIdx = s.phase[6:4];
        case (s.phase[6:5])
            2'h0: begin
                mag[0] = sinA;
                mag[1] = sinB;
                neg = 2'h0;
            end
            2'h1: begin
                mag[0] = sinB;
                mag[1] = sinA;
                neg = 2'h2;
            end
            2'h2: begin
                mag[0] = sinA;
                mag[1] = sinB;
                neg = 2'h3;
            end
            default: begin
                mag[0] = sinB;
                mag[1] = sinA;
                neg = 2'h1;
            end
        endcase
        if (s.mode == MTB_UHALF) begin
            // square table: intermediate points at full scale
            mag[0] = (sqIdx[1:0] == 2'h0) ? 10'h000 : `MTB_FULL_SCALE;
            mag[1] = (sqIdx[1:0] == 2'h2) ? 10'h000 : `MTB_FULL_SCALE;
            neg[0] = sqIdx[2];
            neg[1] = (sqIdx >= 3'h3) && (sqIdx <= 3'h5);
        end
    end

    // ==========================================================
    // register read mux
    always_comb begin
        case (avs_address)
            `MTB_REG_CTRL: rdMux = {21'h0, s.range, s.jit, s.dbl, s.dirCtl, s.mode,
                s.slope, s.en};
            `MTB_REG_STATUS: rdMux = {21'h0, fastDecay, s.rds, posIdx};
            `MTB_REG_SETPT: rdMux = {5'h0, neg[1], mag[1], 5'h0, neg[0], mag[0]};
            `MTB_REG_FAULT: rdMux = {30'h0, s.fault};
            default: rdMux = 32'h0;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        // pins pass two flops before use
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        next_s.stepPrev = s.sync2[0];

        // internal oscillator tick from the system clock
        next_s.oscTick = 1'b0;
        if (s.oscDiv == OSC_LAST) begin
            next_s.oscDiv = 8'h00;
            next_s.oscTick = 1'b1;
        end else begin
            next_s.oscDiv = s.oscDiv + 8'h01;
        end

        // pwm clock counts oscillator ticks only, never load or supply
        pwmEnd = (s.dbl ? PWM_LAST2 : PWM_LAST) + (s.jit ? {5'h0, s.lfsr[2:0]} : 8'h00);
        next_s.pwmStart = 1'b0;
        if (s.oscTick) begin
            if (s.pwmCnt >= pwmEnd) begin
                next_s.pwmCnt = 8'h00;
                next_s.pwmStart = 1'b1;
                next_s.lfsr = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
            end else begin
                next_s.pwmCnt = s.pwmCnt + 8'h01;
            end
        end

        // translator, 7-bit phase wraps in both directions
        if (stepEdge) begin
            next_s.phase = dirUp ? 7'(s.phase + stepSize) : 7'(s.phase - stepSize);
        end

        // low-side resistance: high range and large setpoint use the low value
        for (int c = 0; c < 2; c++) begin
            next_s.rds[c] = !s.range[1] || (mag[c] < `MTB_RDS_THRESH);
        end

        // bus: one wait cycle, then answer
        next_s.waitReq = 1'b1;
        if (reqNew) begin
            next_s.waitReq = 1'b0;
            next_s.rdata = rdMux;
        end
        if (ctrlWr) begin
            next_s.en = avs_writedata[`MTB_CTRL_EN];
            next_s.slope = avs_writedata[`MTB_CTRL_SLOPE +: 2];
            next_s.mode = wrMode;
            next_s.dirCtl = avs_writedata[`MTB_CTRL_DIR];
            next_s.dbl = avs_writedata[`MTB_CTRL_DBL];
        end
        if (wrDone && avs_address == `MTB_REG_CTRL && avs_byteenable[1]) begin
            next_s.jit = avs_writedata[`MTB_CTRL_JIT];
            next_s.range = avs_writedata[`MTB_CTRL_RANGE +: 2];
        end
        // a mode change wins over a step in the same cycle
        if (modeWr) next_s.phase = startPhase(wrMode);
        if (wrDone && avs_address == `MTB_REG_FAULT && avs_byteenable[0]) begin
            next_s.fault = s.fault & ~avs_writedata[1:0];
        end
        // new over-voltage events win over a clear
        next_s.fault = next_s.fault | s.sync2[7:6];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
            s.waitReq <= 1'b1;
            s.lfsr <= `MTB_LFSR_SEED;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // per-coil regulation
    generate
        for (genvar c = 0; c < 2; c++) begin : gCoil
            mtb_coil_pwm #(
                .DEAD_CYC(DEAD_CYC)
            ) uPwm (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .bridgeOn(s.en),
                .pwmStart(s.pwmStart),
                .mag(mag[c]),
                .neg(neg[c]),
                .curAbove(s.sync2[2 + c]),
                .curLimit(s.sync2[4 + c]),
                .shortOff(s.fault[c]),
                .gateHi(gateHi[2 * c +: 2]),
                .gateLo(gateLo[2 * c +: 2]),
                .fastDecay(fastDecay[c])
            );
        end
    endgenerate

    // ==========================================================
    // outputs
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitReq;
    assign bridge_drive_enable = s.en;
    assign slope_select = s.slope;
    assign lowSideRdsonHigh = s.rds;

    // ==========================================================
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_reset_home: assert property ($past(sys_rst) |-> s.phase == 7'h00 && s.mode == MTB_M32)
        else $error("translator not home after reset");
    chk_step_one: assert property (stepEdge && !modeWr |=>
        (s.phase == 7'($past(s.phase) + $past(stepSize))) ||
        (s.phase == 7'($past(s.phase) - $past(stepSize))))
        else $error("step did not move one position");
    chk_mode_home: assert property (modeWr |=> s.phase == startPhase(s.mode))
        else $error("mode change did not go to start");
    chk_half_square: assert property (s.mode == MTB_UHALF && s.phase[4]
        |-> mag[0] == `MTB_FULL_SCALE && mag[1] == `MTB_FULL_SCALE)
        else $error("half step corner not full scale");
    chk_pwm_space: assert property (s.pwmStart |=> !s.pwmStart [*8])
        else $error("pwm period too short");
    chk_bus_answer: assert property (reqNew |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    chk_fault_hold: assert property (s.sync2[6] |=> s.fault[0])
        else $error("over-voltage fault not latched");

endmodule // microstep_translator_bridge_ctrl

`default_nettype wire

// *** bench/mtb_step_host.sv ***
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// microcontroller side: step and direction pins
module mtb_step_host (
    input wire logic clk_sys,
    output logic stepPin,
    output logic dirPin
);
    initial begin
        stepPin = 1'b0;
        dirPin = 1'b0;
    end

    // direction settles 4 cycles ahead of the edge, pulse 4 high, 8 low
    task automatic step(input logic up);
        @(posedge clk_sys);
        dirPin <= up;
        repeat (4) @(posedge clk_sys);
        stepPin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        stepPin <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule // mtb_step_host

`default_nettype wire

// *** bench/microstep_translator_bridge_ctrl_test.sv ***
`timescale 1ns/1ns
`default_nettype none

module microstep_translator_bridge_ctrl_test;
    import mtb_pkg::*;
    logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, bridge_drive_enable;
    logic [3:0] avs_address, gateHi, gateLo, be;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0] curAbove, curLimit, overVolt, slope_select, lowSideRdsonHigh;
    logic stepPin, dirPin;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int sqX[8] = '{0, 100, 100, 100, 0, -100, -100, -100};
    int sqY[8] = '{100, 100, 0, -100, -100, -100, 0, 100};

    microstep_translator_bridge_ctrl #(.OSC_DIV(5), .PWM_TICKS(20), .DEAD_CYC(2)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .advance_step_input(stepPin),
        .stepDirection(dirPin), .curAbove(curAbove), .curLimit(curLimit),
        .overVolt(overVolt), .bridge_drive_enable(bridge_drive_enable),
        .slope_select(slope_select), .gateHi(gateHi), .gateLo(gateLo),
        .lowSideRdsonHigh(lowSideRdsonHigh));
    mtb_step_host host (.clk_sys(clk_sys), .stepPin(stepPin), .dirPin(dirPin));

    // ==========================================================
    // helpers
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until an edge samples waitrequest low; data taken at that same edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        forever begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    function automatic logic [31:0] ctl(logic en, logic [1:0] sl, logic [2:0] m, logic dc);
        return {25'h0, dc, m, sl, en};
    endfunction

    function automatic logic [31:0] sp(int x, int y);
        logic [9:0] mx, my;
        mx = 10'((x < 0 ? -x : x) * 10);
        my = 10'((y < 0 ? -y : y) * 10);
        return {5'h0, y < 0, my, 5'h0, x < 0, mx};
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_reset();
        bus(0, 4'h0, 0); chk(rd, 32'h0);
        bus(0, 4'h4, 0); chk(rd[6:0], 7'h00);
        bus(0, 4'h8, 0); chk(rd, sp(0, 100));
        bus(0, 4'h2, 0); chk(rd, 32'h0);
        chk({bridge_drive_enable, gateHi, gateLo}, 9'h000);
        $display("test reset done");
    endtask

    task automatic t_enable();
        int i;
        bus(1, 4'h0, ctl(1, 2'h2, 3'h0, 0));
        @(posedge clk_sys);
        chk({bridge_drive_enable, slope_select}, 3'h6);
        for (i = 0; i < 400 && gateHi === 4'h0; i++) @(posedge clk_sys);
        chk(gateHi !== 4'h0, 1'b1);
        bus(1, 4'h0, ctl(0, 2'h3, 3'h0, 0) | 32'h80);
        repeat (30) @(posedge clk_sys);
        chk({bridge_drive_enable, slope_select, gateHi, gateLo}, 11'h300);
        // lane 1 only: jitter and range change, lane 0 fields keep their values
        be <= 4'h2;
        bus(1, 4'h0, 32'h0000_0701);
        be <= 4'hF;
        bus(0, 4'h0, 0); chk(rd, 32'h0000_0786);
        chk(lowSideRdsonHigh, 2'h1);
        $display("test enable done");
    endtask

    task automatic t_square();
        int i;
        bus(1, 4'h0, ctl(0, 0, 3'h5, 0));
        bus(0, 4'h8, 0); chk(rd, sp(sqX[0], sqY[0]));
        for (i = 1; i <= 8; i++) begin
            host.step(1'b1);
            bus(0, 4'h4, 0); chk(rd[6:0], 7'(i % 8));
            // x sign follows the half of the cycle, so position 4 reads as minus zero
            bus(0, 4'h8, 0); chk(rd, sp(sqX[i % 8], sqY[i % 8]) | (i % 8 == 4 ? 32'h400 : 32'h0));
        end
        bus(1, 4'h0, ctl(0, 0, 3'h5, 1));
        host.step(1'b1);
        bus(0, 4'h4, 0); chk(rd[6:0], 7'h07);
        $display("test square done");
    endtask

    task automatic t_modes();
        int m;
        for (m = 0; m < 7; m++) begin
            host.step(1'b1);
            bus(1, 4'h0, ctl(0, 0, 3'(m), 0));
            bus(0, 4'h4, 0); chk(rd[6:0], 7'h00);
        end
        bus(0, 4'h8, 0); chk(rd, {16'h028B, 16'h028B});
        host.step(1'b0);
        bus(0, 4'h4, 0); chk(rd[6:0], 7'h03);
        $display("test modes done");
    endtask

    task automatic t_decay();
        bus(1, 4'h0, ctl(1, 0, 3'h5, 0));
        curAbove <= 2'h3;
        host.step(1'b1);
        host.step(1'b1);
        bus(0, 4'h4, 0); chk(rd[10], 1'b1);
        curAbove <= 2'h0;
        repeat (300) @(posedge clk_sys);
        bus(0, 4'h4, 0); chk(rd[10:9], 2'h0);
        // current limit ends forward drive: slow decay on the low switches only
        curLimit <= 2'h3;
        repeat (30) @(posedge clk_sys);
        chk({gateHi, gateLo}, 8'h0F);
        curLimit <= 2'h0;
        $display("test decay done");
    endtask

    task automatic t_fault();
        overVolt <= 2'h1;
        repeat (5) @(posedge clk_sys);
        overVolt <= 2'h0;
        bus(0, 4'hC, 0); chk(rd[1:0], 2'h1);
        repeat (30) @(posedge clk_sys);
        chk({gateHi[1:0], gateLo[1:0]}, 4'h0);
        bus(1, 4'hC, 32'h1);
        bus(0, 4'hC, 0); chk(rd[1:0], 2'h0);
        $display("test fault done");
    endtask

    // ==========================================================
    // clock, watchdogs, main sequence
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys)
        if ((gateHi & gateLo) !== 4'h0) chk(gateHi & gateLo, 32'h0);

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        sys_rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        curAbove = 2'h0;
        curLimit = 2'h0;
        be = 4'hF;
        overVolt = 2'h0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_enable();
        t_square();
        t_modes();
        t_decay();
        t_fault();
        end_of_test();
    end
endmodule // microstep_translator_bridge_ctrl_test

`default_nettype wire
